// ---- hdl/accfg_pkg.sv ----
package accfg_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [7:0] ACCFG_IDX_GENERAL = 8'h0C;
   localparam logic [7:0] ACCFG_IDX_XAXIS = 8'h0D;
   localparam logic [7:0] ACCFG_IDX_YAXIS = 8'h0E;
   localparam logic [7:0] ACCFG_IDX_XARM = 8'h0F;
   localparam logic [7:0] ACCFG_IDX_YARM = 8'h10;
   localparam logic [7:0] ACCFG_IDX_XPTH = 8'h11;
   localparam logic [7:0] ACCFG_IDX_XNTH = 8'h12;
   localparam logic [7:0] ACCFG_IDX_YPTH = 8'h13;
   localparam logic [7:0] ACCFG_IDX_YNTH = 8'h14;
   localparam logic [7:0] ACCFG_IDX_STATUS = 8'h15;
   localparam logic [7:0] ACCFG_IDX_COUNT = 8'h16;
   localparam logic [7:0] ACCFG_IDX_XOFF = 8'h17;
   localparam logic [7:0] ACCFG_IDX_YOFF = 8'h18;
   localparam logic [7:0] ACCFG_IDX_RSVDA = 8'h1C;
   localparam logic [7:0] ACCFG_IDX_RSVDB = 8'h1D;

   // General setup fields
   localparam int ACCFG_GEN_LOCK_BIT = 5;
   localparam int ACCFG_GEN_MODE_LSB = 0;
   // Axis setup fields
   localparam int ACCFG_AX_ST_BIT = 7;
   localparam int ACCFG_AX_LPF_LSB = 0;
   // Arming setup fields
   localparam int ACCFG_ARM_PS_LSB = 4;
   localparam int ACCFG_ARM_WN_LSB = 2;
   localparam int ACCFG_ARM_WP_LSB = 0;
   // Status bit positions
   localparam int ACCFG_ST_IDE = 7;
   localparam int ACCFG_ST_OVR = 6;
   localparam int ACCFG_ST_INIT = 5;
   localparam int ACCFG_ST_MISO = 4;
   localparam int ACCFG_ST_OFFX = 3;
   localparam int ACCFG_ST_OFFY = 2;
   localparam int ACCFG_ST_RES = 1;

   // Arming output modes
   localparam logic [2:0] ACCFG_MODE_OFF = 3'h0;
   localparam logic [2:0] ACCFG_MODE_PCM = 3'h1;
   localparam logic [2:0] ACCFG_MODE_AVG_H = 3'h2;
   localparam logic [2:0] ACCFG_MODE_AVG_L = 3'h3;
   localparam logic [2:0] ACCFG_MODE_CNT_H = 3'h4;
   localparam logic [2:0] ACCFG_MODE_CNT_L = 3'h5;

   // Reset values
   localparam logic [7:0] ACCFG_RST_REG = 8'h00;

   // Timing
   localparam int ACCFG_CLK_MHZ = 125;
   localparam int ACCFG_PRESCALE = 1024;
   localparam int ACCFG_RECOVERY_US = 100;
   localparam int ACCFG_RECOVERY_CYC = ACCFG_RECOVERY_US * ACCFG_CLK_MHZ;
   localparam int ACCFG_INIT_CYC = 64;
endpackage

// ---- hdl/accfg_regs.sv ----
// Summary of operation
// - Mode field selects arming output type
// - Setup registers writable only before lock
// - Self-test bit enables axis self-test
// - Self-test bits cleared at reset
// - Self-test suspends offset cancel and monitor
// - Monitor waits recovery interval after self-test
// - Independent four-bit filter select per axis
// - Arming setup used only in average/count
// - Two-bit pulse stretch per axis
// - Window fields set sample counts
// - Unsigned eight-bit threshold per polarity
// - Zero threshold disables that polarity only
// - Both zero disables axis arming output
// - Status read-only, read clears transients
// - Data error flag, sticky sources reassert
// - Modulator over-range flag, clear on read
// - Init flag high until init completes
// - Serial mismatch flag, clear on read
// - Offset over-range flags, clear on read
// - Reset flag set during init
// - Free-running count after 1024 prescaler
// - Offset correction readback per axis
// - Lock bit sticky until device reset
module accfg_regs
   import accfg_pkg::*;
#(
   parameter int RECOVERY_CYC = ACCFG_RECOVERY_CYC,
   parameter int PRESCALE = ACCFG_PRESCALE
) (
   input wire logic ref_clk, // Core clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [7:0] address, // Word index
   input wire logic read, // Read request
   input wire logic write, // Write request
   input wire logic [31:0] writedata, // Write data
   input wire logic [3:0] byteenable, // Byte lanes
   output logic [31:0] readdata, // Read data
   output logic waitrequest, // Stall
   output logic [1:0] response, // 00 ok, 10 slave error
   input wire logic crcRegFault, // Writable CRC fault
   input wire logic fuseFault, // Fuse array fault
   input wire logic otherFault, // Other internal fault
   input wire logic modOverrange, // Modulator saturation
   input wire logic misoMismatch, // Serial output mismatch
   input wire logic xOffsetLimit, // X offset limit
   input wire logic yOffsetLimit, // Y offset limit
   input wire logic [7:0] xOffsetCorr, // X correction value
   input wire logic [7:0] yOffsetCorr, // Y correction value
   output logic [2:0] armMode, // Effective arming mode
   output logic xArmEnable, // X arming active
   output logic yArmEnable, // Y arming active
   output logic xPosCompare, // X positive compare on
   output logic xNegCompare, // X negative compare on
   output logic yPosCompare, // Y positive compare on
   output logic yNegCompare, // Y negative compare on
   output logic [3:0] xLowpassSelect, // X filter select
   output logic [3:0] yLowpassSelect, // Y filter select
   output logic [5:0] xArmingSetup, // X stretch and windows
   output logic [5:0] yArmingSetup, // Y stretch and windows
   output logic xSelfTest, // X self-test drive
   output logic ySelfTest, // Y self-test drive
   output logic selfTestStatus, // Response status bit
   output logic offsetCancelHold, // Suspend offset cancel
   output logic offsetMonitorHold, // Suspend offset monitor
   output logic initComplete // Lock bit state
);
   // Software-visible registers
   logic [7:0] generalSetup_r; // Lock and mode
   logic [7:0] xAxisSetup_r;
   logic [7:0] yAxisSetup_r;
   logic [7:0] xArmSetup_r;
   logic [7:0] yArmSetup_r;
   logic [7:0] xPosThr_r;
   logic [7:0] xNegThr_r;
   logic [7:0] yPosThr_r;
   logic [7:0] yNegThr_r;
   logic [7:0] status_r; // Fault flags
   logic [7:0] count_r; // Oscillator tick count
   // Internal counters and timers
   logic [9:0] prescale_r; // Divide-by-1024 stage
   logic [31:0] recovery_r; // Monitor hold timer
   logic [6:0] initCnt_r; // Init sequencer
   logic crcSticky_r; // Writable CRC seen
   logic ack_r; // Answer phase
   // Decode helpers
   logic lock; // Setup locked
   logic wrHit;
   logic rdHit;
   logic statusRead;
   logic [7:0] wByte;
   logic mapped;
   logic stAny;
   logic [7:0] rdMux;
   logic [7:0] statusSet;

   assign lock = generalSetup_r[ACCFG_GEN_LOCK_BIT];
   assign wByte = writedata[7:0];
   // Answer edge must not write or read a second time
   assign wrHit = write && !ack_r && byteenable[0];
   assign rdHit = read && !ack_r;
   // Clear fires on the take edge only
   assign statusRead = rdHit && address == ACCFG_IDX_STATUS;
   // Either axis in self-test
   assign stAny = xAxisSetup_r[ACCFG_AX_ST_BIT] ||
      yAxisSetup_r[ACCFG_AX_ST_BIT];

   // Address decode
   always_comb begin
      mapped = 1'b1;
      unique case (address)
         ACCFG_IDX_GENERAL: rdMux = generalSetup_r;
         ACCFG_IDX_XAXIS: rdMux = xAxisSetup_r;
         ACCFG_IDX_YAXIS: rdMux = yAxisSetup_r;
         ACCFG_IDX_XARM: rdMux = xArmSetup_r;
         ACCFG_IDX_YARM: rdMux = yArmSetup_r;
         ACCFG_IDX_XPTH: rdMux = xPosThr_r;
         ACCFG_IDX_XNTH: rdMux = xNegThr_r;
         ACCFG_IDX_YPTH: rdMux = yPosThr_r;
         ACCFG_IDX_YNTH: rdMux = yNegThr_r;
         ACCFG_IDX_STATUS: rdMux = status_r;
         ACCFG_IDX_COUNT: rdMux = count_r;
         // Offsets read live from the cancel logic
         ACCFG_IDX_XOFF: rdMux = xOffsetCorr;
         ACCFG_IDX_YOFF: rdMux = yOffsetCorr;
         // Reserved words read zero, writes dropped
         ACCFG_IDX_RSVDA, ACCFG_IDX_RSVDB: rdMux = 8'h00;
         default: begin
            rdMux = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // Bus handshake: one wait cycle, answer on second edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
         response <= 2'h0;
      end else begin
         // Take on first edge; answer stands one cycle
         ack_r <= (read || write) && !ack_r;
         waitrequest <= !((read || write) && !ack_r);
         // Read data held until the next read
         if (rdHit) begin
            readdata <= {24'h00_0000, rdMux};
         end
         // Unmapped index answers with slave error
         if (rdHit || (write && !ack_r)) begin
            response <= mapped ? 2'h0 : 2'h2;
         end
      end
   end

   // General setup; lock bit only ever sets
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Unlocked after every reset
         generalSetup_r <= ACCFG_RST_REG;
      end else if (wrHit && address == ACCFG_IDX_GENERAL && !lock) begin
         // Lock cannot be written back to zero here
         generalSetup_r <= {2'h0, wByte[5:0]};
      end
   end

   // Axis setup: self-test and filter select
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Self-test always off after reset
         xAxisSetup_r <= ACCFG_RST_REG;
         yAxisSetup_r <= ACCFG_RST_REG;
      end else if (wrHit && !lock) begin
         // Reserved bits dropped; host is expected to write zero
         if (address == ACCFG_IDX_XAXIS) begin
            xAxisSetup_r <= {wByte[7], 3'h0, wByte[3:0]};
         end
         if (address == ACCFG_IDX_YAXIS) begin
            yAxisSetup_r <= {wByte[7], 3'h0, wByte[3:0]};
         end
      end
   end

   // Arming setup and thresholds
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Zero thresholds: arming off until set up
         xArmSetup_r <= ACCFG_RST_REG;
         yArmSetup_r <= ACCFG_RST_REG;
         xPosThr_r <= ACCFG_RST_REG;
         xNegThr_r <= ACCFG_RST_REG;
         yPosThr_r <= ACCFG_RST_REG;
         yNegThr_r <= ACCFG_RST_REG;
      end else if (wrHit && !lock) begin
         unique case (address)
            ACCFG_IDX_XARM: xArmSetup_r <= {2'h0, wByte[5:0]};
            ACCFG_IDX_YARM: yArmSetup_r <= {2'h0, wByte[5:0]};
            ACCFG_IDX_XPTH: xPosThr_r <= wByte;
            ACCFG_IDX_XNTH: xNegThr_r <= wByte;
            ACCFG_IDX_YPTH: yPosThr_r <= wByte;
            ACCFG_IDX_YNTH: yNegThr_r <= wByte;
            // Other indices are handled elsewhere
            default: ;
         endcase
      end
   end

   // Init sequencer after reset release
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         initCnt_r <= 7'h00;
      end else if (initCnt_r != 7'(ACCFG_INIT_CYC)) begin
         // Stops at the terminal count, never wraps
         initCnt_r <= initCnt_r + 7'h01;
      end
   end

   // Latch writable-register CRC fault until reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         crcSticky_r <= 1'b0;
      end else if (crcRegFault && lock) begin
         // Check only runs once setup is locked
         crcSticky_r <= 1'b1;
      end
   end

   // Status flag sources; set wins over read clear
   always_comb begin
      statusSet = 8'h00;
      statusSet[ACCFG_ST_IDE] = crcSticky_r || fuseFault || otherFault;
      statusSet[ACCFG_ST_OVR] = modOverrange;
      statusSet[ACCFG_ST_MISO] = misoMismatch;
      // Offset flags muted while the monitor is held
      statusSet[ACCFG_ST_OFFX] = xOffsetLimit && !offsetMonitorHold;
      statusSet[ACCFG_ST_OFFY] = yOffsetLimit && !offsetMonitorHold;
      // Level during init, so reads then cannot clear it
      statusSet[ACCFG_ST_RES] = initCnt_r != 7'(ACCFG_INIT_CYC);
      // Bit 0 unused, stays zero
   end

   // Status register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= 8'h00;
      end else begin
         // Transient flags: set wins, else clear on read
         for (int i = 0; i < 8; i++) begin
            if (i == ACCFG_ST_INIT) begin
               // Not touched by reads
               status_r[i] <= initCnt_r != 7'(ACCFG_INIT_CYC);
            end else if (statusSet[i]) begin
               status_r[i] <= 1'b1;
            end else if (statusRead) begin
               status_r[i] <= 1'b0;
            end
         end
      end
   end

   // Oscillator check counter
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_r <= 10'h000;
         count_r <= 8'h00;
      end else begin
         // Prescaler wraps after PRESCALE cycles
         prescale_r <= (prescale_r == 10'(PRESCALE - 1)) ?
            10'h000 : prescale_r + 10'h001;
         if (prescale_r == 10'(PRESCALE - 1)) begin
            // Wraps freely at eight bits
            count_r <= count_r + 8'h01;
         end
      end
   end

   // Offset monitor hold after self-test drops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         recovery_r <= 32'h0000_0000;
      end else if (stAny) begin
         // Reload while any self-test is on
         recovery_r <= 32'(RECOVERY_CYC);
      end else if (recovery_r != 32'h0000_0000) begin
         // Count down once self-test drops
         recovery_r <= recovery_r - 32'h0000_0001;
      end
   end

   // Registered control outputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Everything quiet while reset is held
         armMode <= ACCFG_MODE_OFF;
         xArmEnable <= 1'b0;
         yArmEnable <= 1'b0;
         xPosCompare <= 1'b0;
         xNegCompare <= 1'b0;
         yPosCompare <= 1'b0;
         yNegCompare <= 1'b0;
         xLowpassSelect <= 4'h0;
         yLowpassSelect <= 4'h0;
         xArmingSetup <= 6'h00;
         yArmingSetup <= 6'h00;
         xSelfTest <= 1'b0;
         ySelfTest <= 1'b0;
         selfTestStatus <= 1'b0;
         offsetCancelHold <= 1'b0;
         offsetMonitorHold <= 1'b0;
         initComplete <= 1'b0;
      end else begin
         armMode <= generalSetup_r[ACCFG_GEN_MODE_LSB +: 3];
         // Both thresholds zero kills the axis in any mode
         xArmEnable <= (xPosThr_r != 8'h00) ||
            (xNegThr_r != 8'h00);
         yArmEnable <= (yPosThr_r != 8'h00) ||
            (yNegThr_r != 8'h00);
         // Zero threshold turns only that polarity off
         xPosCompare <= xPosThr_r != 8'h00;
         xNegCompare <= xNegThr_r != 8'h00;
         yPosCompare <= yPosThr_r != 8'h00;
         yNegCompare <= yNegThr_r != 8'h00;
         xLowpassSelect <= xAxisSetup_r[ACCFG_AX_LPF_LSB +: 4];
         yLowpassSelect <= yAxisSetup_r[ACCFG_AX_LPF_LSB +: 4];
         // Only average and count modes use the arming setup
         if (generalSetup_r[2:0] >= ACCFG_MODE_AVG_H &&
             generalSetup_r[2:0] <= ACCFG_MODE_CNT_L) begin
            xArmingSetup <= xArmSetup_r[5:0];
            yArmingSetup <= yArmSetup_r[5:0];
         end else begin
            xArmingSetup <= 6'h00;
            yArmingSetup <= 6'h00;
         end
         // Self-test drive follows the register bits
         xSelfTest <= xAxisSetup_r[ACCFG_AX_ST_BIT];
         ySelfTest <= yAxisSetup_r[ACCFG_AX_ST_BIT];
         // Status drops at once, monitor hold waits
         selfTestStatus <= stAny;
         offsetCancelHold <= stAny;
         offsetMonitorHold <= stAny || recovery_r != 32'h0000_0000;
         // Lock state mirrored for the far side
         initComplete <= lock;
      end
   end
endmodule

// ---- dv/accfg_chk.sv ----
module accfg_chk
   import accfg_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic reset_n, // Reset, active low
   input wire logic read, // Read request
   input wire logic write, // Write request
   input wire logic waitrequest, // Stall
   input wire logic [2:0] armMode, // Arming mode
   input wire logic xArmEnable, // X arming on
   input wire logic xPosCompare, // X positive on
   input wire logic xNegCompare, // X negative on
   input wire logic [3:0] xLowpassSelect, // X filter
   input wire logic [5:0] xArmingSetup, // X arming setup
   input wire logic xSelfTest, // X self-test
   input wire logic ySelfTest, // Y self-test
   input wire logic selfTestStatus, // Status bit
   input wire logic offsetCancelHold, // Cancel hold
   input wire logic offsetMonitorHold, // Monitor hold
   input wire logic initComplete // Lock state
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so one default for all
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // Answer one cycle after take, low for one cycle only
   answer_time_a: assert property ($rose(read || write) |=> !waitrequest)
      else $error("no answer after request");
   wait_one_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held too long");
   reset_clear_a: assert property ($rose(reset_n) |->
      !initComplete && !xSelfTest && !ySelfTest)
      else $error("state left over from reset");
   lock_hold_a: assert property (initComplete |=> initComplete)
      else $error("lock bit cleared");
   // Locked mode, X filter, X arming setup and X positive compare must not move at all
   lock_freeze_a: assert property (initComplete |=>
      $stable(armMode) &&
      $stable(xLowpassSelect) && $stable(xArmingSetup) &&
      $stable(xPosCompare))
      else $error("locked setup changed");
   st_status_a: assert property (
      selfTestStatus == (xSelfTest || ySelfTest))
      else $error("self-test status wrong");
   st_hold_a: assert property ((xSelfTest || ySelfTest) |->
      offsetCancelHold && offsetMonitorHold)
      else $error("offset logic not held");
   monitor_recover_a: assert property ($fell(xSelfTest || ySelfTest)
      |-> offsetMonitorHold [*8])
      else $error("monitor released early");
   arm_enable_a: assert property (
      xArmEnable == (xPosCompare || xNegCompare))
      else $error("arm enable wrong");
   arm_gate_a: assert property ((armMode < 3'h2 || armMode > 3'h5) |->
      xArmingSetup == 6'h00)
      else $error("arming setup leaks");

   cover property ($rose(initComplete));
   cover property ($fell(xSelfTest));
   cover property (read && !waitrequest);
endmodule

// ---- dv/accfg_host.sv ----
module accfg_host (
   input wire logic ref_clk, // Clock
   input wire logic waitrequest, // Stall
   input wire logic [31:0] readdata, // Read data
   input wire logic [1:0] response, // Response code
   output logic [7:0] address, // Word index
   output logic read, // Read request
   output logic write, // Write request
   output logic [31:0] writedata, // Write data
   output logic [3:0] byteenable // Byte lanes
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus from time zero
   initial begin
      address = 8'h00;
      read = 1'h0;
      write = 1'h0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
   end
   // Request held until waitrequest is sampled low
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      address <= a;
      writedata <= {24'h000000, v};
      write <= 1'h1;
      do @(posedge ref_clk); while (waitrequest !== 1'h0);
      write <= 1'h0;
      // Released lines show no stale value
      address <= ~a;
      writedata <= ~{24'h000000, v};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v,
      output logic [1:0] rsp);
      @(posedge ref_clk);
      address <= a;
      read <= 1'h1;
      do @(posedge ref_clk); while (waitrequest !== 1'h0);
      v = readdata[7:0];
      rsp = response;
      read <= 1'h0;
      address <= ~a;
   endtask
endmodule

// ---- dv/accfg_regs_tb.sv ----
module accfg_regs_tb
   import accfg_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RCYC = 20; // Short recovery keeps run brief
   localparam int PSC = 4; // Short prescale
   localparam logic [7:0] STB [0:5] = '{8'h04, 8'h08, 8'h10, 8'h40, 8'h80,
      8'h80}; // Status bit per event
   logic ref_clk = 1'h0; // Clock
   logic reset_n = 1'h0; // Reset, active low
   logic crcRegFault = 1'h0; // CRC fault event
   logic [5:0] ev = 6'h00; // Fault events
   logic [7:0] xOffsetCorr = 8'h00, yOffsetCorr = 8'h00; // Corrections
   logic [7:0] address, d, c0, a, v; // Bus and scratch
   logic read, write, waitrequest;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable, xLowpassSelect, yLowpassSelect;
   logic [1:0] response, r;
   logic [2:0] armMode; // Design outputs
   logic xArmEnable, yArmEnable, xPosCompare, xNegCompare, yPosCompare;
   logic yNegCompare, xSelfTest, ySelfTest, selfTestStatus, initComplete;
   logic offsetCancelHold, offsetMonitorHold;
   logic [5:0] xArmingSetup, yArmingSetup;
   int miscompares = 0, check_count = 0, seed = 25108, cyc = 0;

   always #4 ref_clk = ~ref_clk;

   accfg_regs #(.RECOVERY_CYC(RCYC), .PRESCALE(PSC)) i_dut (
      .ref_clk, .reset_n, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .response, .crcRegFault, .fuseFault(ev[5]),
      .otherFault(ev[4]), .modOverrange(ev[3]), .misoMismatch(ev[2]),
      .xOffsetLimit(ev[1]), .yOffsetLimit(ev[0]), .xOffsetCorr, .yOffsetCorr,
      .armMode, .xArmEnable, .yArmEnable, .xPosCompare, .xNegCompare,
      .yPosCompare, .yNegCompare, .xLowpassSelect, .yLowpassSelect,
      .xArmingSetup, .yArmingSetup, .xSelfTest, .ySelfTest, .selfTestStatus,
      .offsetCancelHold, .offsetMonitorHold, .initComplete);
   accfg_host i_host (.ref_clk, .waitrequest, .readdata, .response,
      .address, .read, .write, .writedata, .byteenable);

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Register read value against expectation
   task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
      check_count++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // Port values, padded to a byte
   task automatic chk_port(input logic [7:0] g, input logic [7:0] x);
      chk_reg(g, x);
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [7:0] x);
      i_host.rd(ad, d, r);
      chk_reg(d, x);
   endtask
   // Readback mask; reserved bits read zero
   function automatic logic [7:0] wmask(input logic [7:0] ad);
      case (ad)
         ACCFG_IDX_GENERAL: return 8'h07;
         ACCFG_IDX_XAXIS, ACCFG_IDX_YAXIS: return 8'h8F;
         ACCFG_IDX_XARM, ACCFG_IDX_YARM: return 8'h3F;
         default: return 8'hFF;
      endcase
   endfunction
   // Arming setup only passes in average and count modes
   function automatic logic [7:0] armexp(input int m, input logic [7:0] s);
      return (m >= 2 && m <= 5) ? {2'h0, s[5:0]} : 8'h00;
   endfunction

   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'h1;
      rdc(ACCFG_IDX_STATUS, 8'h22);
      rdc(ACCFG_IDX_STATUS, 8'h22);
      rdc(ACCFG_IDX_RSVDA, 8'h00);
      rdc(ACCFG_IDX_RSVDB, 8'h00);
      chk_port({6'h00, r}, 8'h00);
      i_host.rd(8'h30, d, r);
      chk_port({6'h00, r}, 8'h02);
      chk_port(readdata[31:24] | readdata[23:16] | readdata[15:8], 8'h00);
      repeat (64) @(posedge ref_clk);
      // Reset flag stays latched until the first read after init
      rdc(ACCFG_IDX_STATUS, 8'h02);
      rdc(ACCFG_IDX_STATUS, 8'h00);
      $display("test init done");
      for (int i = 0; i < 40; i++) begin
         a = ACCFG_IDX_GENERAL + 8'($unsigned($random(seed)) % 9);
         v = 8'($random(seed)) & wmask(a);
         i_host.wr(a, v);
         rdc(a, v);
      end
      i_host.wr(ACCFG_IDX_XARM, 8'h2D);
      i_host.wr(ACCFG_IDX_XPTH, 8'h00);
      i_host.wr(ACCFG_IDX_XNTH, 8'hFF);
      i_host.wr(ACCFG_IDX_YARM, 8'h1B);
      i_host.wr(ACCFG_IDX_YPTH, 8'h07);
      i_host.wr(ACCFG_IDX_YNTH, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk_port({5'h0, xPosCompare, xNegCompare, xArmEnable}, 8'h03);
      chk_port({5'h0, yPosCompare, yNegCompare, yArmEnable}, 8'h05);
      i_host.wr(ACCFG_IDX_XNTH, 8'h00);
      repeat (2) @(posedge ref_clk);
      chk_port({7'h00, xArmEnable}, 8'h00);
      i_host.wr(ACCFG_IDX_XNTH, 8'h01);
      for (int m = 0; m < 8; m++) begin
         i_host.wr(ACCFG_IDX_GENERAL, 8'(m));
         repeat (2) @(posedge ref_clk);
         chk_port({5'h00, armMode}, 8'(m));
         chk_port({2'h0, xArmingSetup}, armexp(m, 8'h2D));
         chk_port({2'h0, yArmingSetup}, armexp(m, 8'h1B));
      end
      $display("test setup done");
      i_host.wr(ACCFG_IDX_XAXIS, 8'h85);
      i_host.wr(ACCFG_IDX_YAXIS, 8'h0A);
      repeat (2) @(posedge ref_clk);
      chk_port({xSelfTest, selfTestStatus, offsetCancelHold,
         offsetMonitorHold, xLowpassSelect}, 8'hF5);
      chk_port({ySelfTest, 3'h0, yLowpassSelect}, 8'h0A);
      i_host.wr(ACCFG_IDX_XAXIS, 8'h05);
      repeat (2) @(posedge ref_clk);
      chk_port({xSelfTest, selfTestStatus, offsetCancelHold,
         offsetMonitorHold, xLowpassSelect}, 8'h15);
      repeat (RCYC + 4) @(posedge ref_clk);
      chk_port({7'h00, offsetMonitorHold}, 8'h00);
      $display("test selftest done");
      // One event at a time, then read twice
      for (int k = 0; k < 6; k++) begin
         ev <= 6'(1 << k);
         @(posedge ref_clk);
         ev <= 6'h00;
         rdc(ACCFG_IDX_STATUS, STB[k]);
         rdc(ACCFG_IDX_STATUS, 8'h00);
      end
      i_host.rd(ACCFG_IDX_COUNT, c0, r);
      repeat (37) @(posedge ref_clk);
      i_host.rd(ACCFG_IDX_COUNT, d, r);
      chk_reg(d - c0, 8'(40 / PSC));
      xOffsetCorr <= 8'($random(seed));
      yOffsetCorr <= 8'($random(seed));
      @(posedge ref_clk);
      rdc(ACCFG_IDX_XOFF, xOffsetCorr);
      rdc(ACCFG_IDX_YOFF, yOffsetCorr);
      $display("test status done");
      i_host.wr(ACCFG_IDX_GENERAL, 8'h22);
      i_host.wr(ACCFG_IDX_XAXIS, 8'h8F);
      i_host.wr(ACCFG_IDX_GENERAL, 8'h00);
      rdc(ACCFG_IDX_XAXIS, 8'h05);
      rdc(ACCFG_IDX_GENERAL, 8'h22);
      chk_port({7'h00, xSelfTest}, 8'h00);
      crcRegFault <= 1'h1;
      @(posedge ref_clk);
      crcRegFault <= 1'h0;
      rdc(ACCFG_IDX_STATUS, 8'h80);
      rdc(ACCFG_IDX_STATUS, 8'h80);
      reset_n <= 1'h0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      rdc(ACCFG_IDX_STATUS, 8'h22);
      rdc(ACCFG_IDX_GENERAL, 8'h00);
      rdc(ACCFG_IDX_XAXIS, 8'h00);
      $display("test lock done");
      stop_test();
   end
endmodule

bind accfg_regs accfg_chk i_chk (.ref_clk, .reset_n, .read, .write,
   .waitrequest, .armMode, .xArmEnable, .xPosCompare, .xNegCompare,
   .xLowpassSelect, .xArmingSetup, .xSelfTest, .ySelfTest, .selfTestStatus,
   .offsetCancelHold, .offsetMonitorHold, .initComplete);
